// file: pmu_i2c_housekeeping_ctrl.sv
module pmu_i2c_housekeeping_ctrl #(
	parameter int unsigned SOFT_START_CYCLES_P = pmu_link_pkg::SOFT_START_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	pmu_i2c_link_if.device link,
	input wire logic battery_below_raw,
	input wire logic battery_recovered_raw,
	input wire logic temp_warn_raw,
	input wire logic temp_over_raw,
	input wire logic temp_cooled_raw,
	input wire logic voltage_select_pin,
	input wire logic [pmu_link_pkg::NUM_BUCK-1:0] reg_fault_raw,
	output logic [3:0] battery_threshold_code,
	output logic battery_monitor_on,
	output logic [pmu_link_pkg::NUM_BUCK-1:0] reg_on,
	output logic [pmu_link_pkg::NUM_BUCK-1:0] soft_start,
	output logic [pmu_link_pkg::NUM_SEL-1:0][pmu_link_pkg::VSET_W-1:0] vset_target,
	output logic interrupt_out_n_o,
	output logic interrupt_out_n_oe
);
	import pmu_link_pkg::*;

	localparam int SYNC_W = 8 + NUM_BUCK;

	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_q;
	logic scl_s, sda_s, scl_d, sda_d;
	logic bat_below, bat_rec, warn, over, cooled, vsel;
	logic [NUM_BUCK-1:0] fault, fault_d, reg_on_d;
	logic scl_rise, scl_fall, start_seen, stop_seen;
	slave_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] tx;
	logic rw;
	logic [7:0] reg_addr;
	logic sda_oe;
	logic wr_pulse;
	logic [7:0] read_value;
	logic battery_irq_enable, thermal_irq_enable, battery_low_flag, lockout;
	logic [NUM_BUCK-1:0] enable;
	logic [NUM_SEL-1:0][VSET_W-1:0] voltage_setting_a;
	logic [NUM_SEL-1:0][VSET_W-1:0] voltage_setting_b;
	logic irq_pending;

	// Two-stage synchronizer for every outside input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_meta <= {2'b11, {(SYNC_W-2){1'b0}}};
			sync_q <= {2'b11, {(SYNC_W-2){1'b0}}};
		end else begin
			sync_meta <= {link.scl, link.sda, battery_below_raw, battery_recovered_raw, temp_warn_raw,
				temp_over_raw, temp_cooled_raw, voltage_select_pin, reg_fault_raw};
			sync_q <= sync_meta;
		end
	end
	assign {scl_s, sda_s, bat_below, bat_rec, warn, over, cooled, vsel, fault} = sync_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_seen = scl_s && scl_d && sda_d && !sda_s;
	assign stop_seen = scl_s && scl_d && !sda_d && sda_s;

	// Register read mux
	always_comb begin
		read_value = 8'h00;
		case (reg_addr)
			REG_BATTERY: begin
				read_value[3:0] = battery_threshold_code;
				read_value[BAT_MON_ON_BIT] = battery_monitor_on;
				read_value[BAT_IRQ_EN_BIT] = battery_irq_enable;
			end
			REG_STATUS: begin
				read_value[STAT_BAT_LOW_BIT] = battery_low_flag;
				read_value[STAT_WARN_BIT] = warn;
				read_value[STAT_LOCK_BIT] = lockout;
				read_value[STAT_IRQ_BIT] = irq_pending;
			end
			REG_THERMAL: read_value[THERM_IRQ_EN_BIT] = thermal_irq_enable;
			REG_ENABLE: read_value[NUM_BUCK-1:0] = enable;
			default: begin
				for (int i = 0; i < NUM_SEL; i++) begin
					if (reg_addr == REG_VSET_A_BASE + 8'(i)) read_value[VSET_W-1:0] = voltage_setting_a[i];
					if (reg_addr == REG_VSET_B_BASE + 8'(i)) read_value[VSET_W-1:0] = voltage_setting_b[i];
				end
			end
		endcase
	end

	// Slave protocol engine; only ever pulls SDA, SCL is input only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift_in <= 8'h00;
			tx <= 8'h00;
			rw <= 1'b0;
			reg_addr <= 8'h00;
			sda_oe <= 1'b0;
			wr_pulse <= 1'b0;
		end else begin
			wr_pulse <= 1'b0;
			if (start_seen) begin
				state <= ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_seen) begin
				state <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_REG, ST_WDATA: begin
						shift_in <= {shift_in[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_RDATA: begin
						tx <= {tx[6:0], 1'b0};
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_MACK: begin
						if (sda_s) begin
							state <= ST_IGNORE;
						end else begin
							state <= ST_RDATA;
							bit_cnt <= 4'h0;
							tx <= read_value;
						end
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						if (bit_cnt == 4'h8) begin
							if (shift_in[7:1] == DEVICE_ADDR) begin
								rw <= shift_in[0];
								sda_oe <= 1'b1;
								state <= ST_ACK_ADDR;
							end else begin
								state <= ST_IGNORE;
							end
						end
					end
					ST_REG: begin
						if (bit_cnt == 4'h8) begin
							reg_addr <= shift_in;
							sda_oe <= 1'b1;
							state <= ST_ACK_REG;
						end
					end
					ST_WDATA: begin
						if (bit_cnt == 4'h8) begin
							wr_pulse <= 1'b1;
							sda_oe <= 1'b1;
							state <= ST_ACK_WDATA;
						end
					end
					ST_ACK_ADDR: begin
						bit_cnt <= 4'h0;
						if (rw) begin
							tx <= read_value;
							sda_oe <= !read_value[7];
							state <= ST_RDATA;
						end else begin
							sda_oe <= 1'b0;
							state <= ST_REG;
						end
					end
					ST_ACK_REG: begin
						bit_cnt <= 4'h0;
						sda_oe <= 1'b0;
						state <= ST_WDATA;
					end
					ST_ACK_WDATA: begin
						sda_oe <= 1'b0;
						state <= ST_IGNORE;
					end
					ST_RDATA: begin
						if (bit_cnt == 4'h8) begin
							sda_oe <= 1'b0;
							state <= ST_MACK;
						end else begin
							sda_oe <= !tx[7];
						end
					end
					default: ;
				endcase
			end
		end
	end
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = sda_oe;

	// Register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			battery_threshold_code <= BAT_CODE_RESET;
			battery_monitor_on <= 1'b0;
			battery_irq_enable <= 1'b0;
			thermal_irq_enable <= 1'b0;
			enable <= ENABLE_RESET;
			voltage_setting_a <= {NUM_SEL{VSET_A_RESET}};
			voltage_setting_b <= {NUM_SEL{VSET_B_RESET}};
		end else if (wr_pulse) begin
			case (reg_addr)
				REG_BATTERY: begin
					battery_threshold_code <= shift_in[3:0];
					battery_monitor_on <= 1'b1;
					battery_irq_enable <= shift_in[BAT_IRQ_EN_BIT];
				end
				REG_THERMAL: thermal_irq_enable <= shift_in[THERM_IRQ_EN_BIT];
				REG_ENABLE: enable <= shift_in[NUM_BUCK-1:0];
				default: begin
					for (int i = 0; i < NUM_SEL; i++) begin
						if (reg_addr == REG_VSET_A_BASE + 8'(i)) voltage_setting_a[i] <= shift_in[VSET_W-1:0];
						if (reg_addr == REG_VSET_B_BASE + 8'(i)) voltage_setting_b[i] <= shift_in[VSET_W-1:0];
					end
				end
			endcase
		end
	end

	// Battery comparator with hysteresis, thermal lockout, interrupt
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			battery_low_flag <= 1'b0;
			lockout <= 1'b0;
			interrupt_out_n_oe <= 1'b0;
		end else begin
			if (!battery_monitor_on) battery_low_flag <= 1'b0;
			else if (bat_below) battery_low_flag <= 1'b1;
			else if (bat_rec) battery_low_flag <= 1'b0;
			if (over) lockout <= 1'b1;
			else if (cooled) lockout <= 1'b0;
			interrupt_out_n_oe <= irq_pending;
		end
	end
	assign irq_pending = (battery_low_flag && battery_irq_enable) || (warn && thermal_irq_enable);
	assign interrupt_out_n_o = 1'b0;

	// Regulator enables and pin-selected voltage targets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_on <= '0;
			reg_on_d <= '0;
			fault_d <= '0;
			vset_target <= {NUM_SEL{VSET_A_RESET}};
		end else begin
			reg_on <= enable & {NUM_BUCK{!lockout}};
			reg_on_d <= reg_on;
			fault_d <= fault;
			for (int i = 0; i < NUM_SEL; i++) begin
				vset_target[i] <= vsel ? voltage_setting_b[i] : voltage_setting_a[i];
			end
		end
	end

	// Soft-start window per regulator
	for (genvar g = 0; g < NUM_BUCK; g++) begin : g_soft
		logic [15:0] ss_cnt;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ss_cnt <= 16'h0000;
				soft_start[g] <= 1'b0;
			end else if ((reg_on[g] && !reg_on_d[g]) || (reg_on[g] && fault_d[g] && !fault[g])) begin
				ss_cnt <= 16'(SOFT_START_CYCLES_P - 1);
				soft_start[g] <= 1'b1;
			end else if (ss_cnt != 16'h0000) begin
				ss_cnt <= ss_cnt - 16'h0001;
			end else begin
				soft_start[g] <= 1'b0;
			end
		end
	end
endmodule // pmu_i2c_housekeeping_ctrl

// file: pmu_link_pkg.sv
package pmu_link_pkg;
	localparam logic [6:0] DEVICE_ADDR = 7'h5A;
	localparam int VSET_W = 6;
	localparam int NUM_BUCK = 4;
	localparam int NUM_SEL = 3;
	// Device register addresses on the link
	localparam logic [7:0] REG_BATTERY = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_THERMAL = 8'h02;
	localparam logic [7:0] REG_ENABLE = 8'h03;
	localparam logic [7:0] REG_VSET_A_BASE = 8'h10;
	localparam logic [7:0] REG_VSET_B_BASE = 8'h14;
	// Field positions
	localparam int BAT_MON_ON_BIT = 4;
	localparam int BAT_IRQ_EN_BIT = 5;
	localparam int THERM_IRQ_EN_BIT = 0;
	localparam int STAT_BAT_LOW_BIT = 0;
	localparam int STAT_WARN_BIT = 1;
	localparam int STAT_LOCK_BIT = 2;
	localparam int STAT_IRQ_BIT = 3;
	// Reset values
	localparam logic [3:0] BAT_CODE_RESET = 4'h0;
	localparam logic [3:0] ENABLE_RESET = 4'h0;
	localparam logic [5:0] VSET_A_RESET = 6'h00;
	localparam logic [5:0] VSET_B_RESET = 6'h00;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
	localparam int SOFT_START_US = 400;
	localparam int SOFT_START_CYCLES = SOFT_START_US * CLK_MHZ;
	localparam int I2C_FREQ_KHZ = 400;
	localparam int I2C_QUARTER_NS = 1000000 / I2C_FREQ_KHZ / 4;
	localparam int I2C_QUARTER_CYCLES = (I2C_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Host register offsets and fields
	localparam logic [3:0] HOST_CMD = 4'h0;
	localparam logic [3:0] HOST_STATUS = 4'h4;
	localparam logic [3:0] HOST_RDATA = 4'h8;
	localparam int CMD_REG_LSB = 0;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_READ_BIT = 16;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_NACK_BIT = 1;
	localparam int ST_DONE_BIT = 2;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ACK_ADDR = 4'b0010,
		ST_REG = 4'b0011,
		ST_ACK_REG = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_ACK_WDATA = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_MACK = 4'b1000,
		ST_IGNORE = 4'b1001
	} slave_state_t;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_START = 2'b01,
		M_BIT = 2'b10,
		M_STOP = 2'b11
	} master_state_t;
endpackage

// file: pmu_i2c_link_if.sv
interface pmu_i2c_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// Open-drain wires with pull-ups
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport device(input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host(input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// file: pmu_i2c_host_ctrl.sv
module pmu_i2c_host_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	pmu_i2c_link_if.host link
);
	import pmu_link_pkg::*;

	logic aw_held, w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] cmd;
	logic launch;
	logic busy, nack_err, done;
	logic [7:0] rx;
	logic [1:0] sda_sync;
	logic sda_s;
	master_state_t mstate;
	logic [7:0] qcnt;
	logic tick;
	logic [1:0] phase;
	logic [2:0] byte_idx;
	logic [3:0] bit_idx;
	logic ack_bad;
	logic [7:0] op_reg, op_data;
	logic op_rd;
	logic [7:0] byte_out;
	logic scl_oe, sda_oe;

	// AXI4-Lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == HOST_CMD) ? AXI_OKAY : AXI_SLVERR;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Command register; a write while busy is dropped
	assign launch = aw_held && w_held && !s_axi_bvalid && (aw_addr == HOST_CMD) && !busy && (w_strb != 4'h0);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd <= 32'h0000_0000;
		end else if (launch) begin
			for (int i = 0; i < 3; i++) begin
				if (w_strb[i]) cmd[i*8 +: 8] <= w_data[i*8 +: 8];
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= AXI_OKAY;
			case (s_axi_araddr)
				HOST_CMD: s_axi_rdata <= {15'h0000, cmd[CMD_READ_BIT:0]};
				HOST_STATUS: s_axi_rdata <= {29'h0000_0000, done, nack_err, busy};
				HOST_RDATA: s_axi_rdata <= {24'h00_0000, rx};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// SDA sampled through two flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) sda_sync <= 2'b11;
		else sda_sync <= {sda_sync[0], link.sda};
	end
	assign sda_s = sda_sync[1];

	// Quarter-bit timer, 400 kHz at most
	assign tick = (qcnt == 8'(I2C_QUARTER_CYCLES - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn || mstate == M_IDLE || tick) qcnt <= 8'h00;
		else qcnt <= qcnt + 8'h01;
	end

	always_comb begin
		case (byte_idx)
			3'h0: byte_out = {DEVICE_ADDR, 1'b0};
			3'h1: byte_out = op_reg;
			3'h2: byte_out = op_data;
			3'h3: byte_out = {DEVICE_ADDR, 1'b1};
			default: byte_out = 8'h00;
		endcase
	end

	// Bus master sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mstate <= M_IDLE;
			phase <= 2'h0;
			byte_idx <= 3'h0;
			bit_idx <= 4'h0;
			ack_bad <= 1'b0;
			busy <= 1'b0;
			nack_err <= 1'b0;
			done <= 1'b0;
			rx <= 8'h00;
			op_reg <= 8'h00;
			op_data <= 8'h00;
			op_rd <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (mstate == M_IDLE) begin
			if (launch) begin
				mstate <= M_START;
				phase <= 2'h0;
				byte_idx <= 3'h0;
				ack_bad <= 1'b0;
				busy <= 1'b1;
				done <= 1'b0;
				nack_err <= 1'b0;
				op_reg <= w_strb[0] ? w_data[CMD_REG_LSB +: 8] : cmd[CMD_REG_LSB +: 8];
				op_data <= w_strb[1] ? w_data[CMD_DATA_LSB +: 8] : cmd[CMD_DATA_LSB +: 8];
				op_rd <= w_strb[2] ? w_data[CMD_READ_BIT] : cmd[CMD_READ_BIT];
			end
		end else if (tick) begin
			phase <= phase + 2'h1;
			case (mstate)
				M_START: begin
					case (phase)
						2'h0: sda_oe <= 1'b0;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b1;
						default: begin
							scl_oe <= 1'b1;
							bit_idx <= 4'h0;
							mstate <= M_BIT;
						end
					endcase
				end
				M_BIT: begin
					case (phase)
						2'h0: sda_oe <= (bit_idx < 4'h8) && (byte_idx != 3'h4) && !byte_out[3'(4'h7 - bit_idx)];
						2'h1: scl_oe <= 1'b0;
						2'h2: begin
							if (bit_idx < 4'h8 && byte_idx == 3'h4) rx <= {rx[6:0], sda_s};
							if (bit_idx == 4'h8 && byte_idx != 3'h4 && sda_s) ack_bad <= 1'b1;
						end
						default: begin
							scl_oe <= 1'b1;
							if (bit_idx < 4'h8) begin
								bit_idx <= bit_idx + 4'h1;
							end else begin
								bit_idx <= 4'h0;
								if (ack_bad) begin
									nack_err <= 1'b1;
									mstate <= M_STOP;
								end else if (byte_idx == 3'h1 && op_rd) begin
									byte_idx <= 3'h3;
									mstate <= M_START;
								end else if (byte_idx == 3'h2 || byte_idx == 3'h4) begin
									mstate <= M_STOP;
								end else begin
									byte_idx <= byte_idx + 3'h1;
								end
							end
						end
					endcase
				end
				M_STOP: begin
					case (phase)
						2'h0: begin
							scl_oe <= 1'b1;
							sda_oe <= 1'b1;
						end
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b0;
						default: begin
							busy <= 1'b0;
							done <= 1'b1;
							mstate <= M_IDLE;
						end
					endcase
				end
				default: mstate <= M_IDLE;
			endcase
		end
	end
	assign link.host_scl_o = 1'b0;
	assign link.host_scl_oe = scl_oe;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = sda_oe;
endmodule // pmu_i2c_host_ctrl

// file: pmu_i2c_link_props.sv
module pmu_i2c_link_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	import pmu_link_pkg::*;
	logic scl_q, sda_q, in_frame, rw;
	logic [3:0] bitcnt;
	logic [1:0] nbyte;
	logic [7:0] shift;
	logic [8:0] per_cnt;
	wire logic scl_rise = scl && !scl_q;
	wire logic scl_fall = !scl && scl_q;
	wire logic start_ev = scl && scl_q && sda_q && !sda;
	wire logic stop_ev = scl && scl_q && !sda_q && sda;
	wire logic ack_rise = scl_rise && in_frame && bitcnt == 4'h8;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Bus edges and frame state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			in_frame <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start_ev) begin
				in_frame <= 1'b1;
			end else if (stop_ev) begin
				in_frame <= 1'b0;
			end
		end
	end
	// Bit and byte position, captured byte and direction
	always_ff @(posedge aclk) begin
		if (!aresetn || start_ev) begin
			bitcnt <= 4'h0;
			nbyte <= 2'h0;
		end else if (scl_rise && in_frame) begin
			if (bitcnt == 4'h8) begin
				bitcnt <= 4'h0;
				nbyte <= nbyte + 2'(nbyte != 2'h3);
				if (nbyte == 2'h0) begin
					rw <= shift[0];
				end
			end else begin
				bitcnt <= bitcnt + 4'h1;
				shift <= {shift[6:0], sda};
			end
		end
	end
	// Cycles since the last clock rise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_cnt <= 9'h1ff;
		end else if (scl_rise) begin
			per_cnt <= 9'h001;
		end else if (per_cnt != 9'h1ff) begin
			per_cnt <= per_cnt + 9'h001;
		end
	end
	chk_dev_pull_low: assert property ($rose(dev_sda_oe) |-> !scl)
		else $error("device pulled SDA while SCL was high");
	chk_dev_sda_steady: assert property (scl && scl_q |-> $stable(dev_sda_oe))
		else $error("device changed SDA while SCL was high");
	chk_start_first: assert property ($rose(host_scl_oe) |-> in_frame)
		else $error("clock pulled low outside a frame");
	chk_addr_ack: assert property (ack_rise && nbyte == 2'h0 && shift[7:1] == DEVICE_ADDR |-> !sda)
		else $error("own address not acknowledged");
	chk_data_ack: assert property (ack_rise && !rw && nbyte inside {2'h1, 2'h2} |-> !sda)
		else $error("written byte not acknowledged");
	chk_ack_release: assert property (scl_fall && in_frame && bitcnt == 4'h0 && nbyte != 2'h0 && !rw
		|-> ##[1:8] !dev_sda_oe) else $error("acknowledge not released");
	chk_idle_quiet: assert property (!in_frame |-> !dev_sda_oe)
		else $error("device drove SDA outside a frame");
	chk_bus_rate: assert property (scl_rise && in_frame |-> per_cnt >= 9'h0fa)
		else $error("bus clock faster than allowed");
	cover property (start_ev);
	cover property (ack_rise && nbyte == 2'h0 && !sda);
	cover property (ack_rise && rw && nbyte == 2'h1 && sda);
endmodule // pmu_i2c_link_props

// file: tb_pmu_i2c_housekeeping_ctrl.sv
module tb_pmu_i2c_housekeeping_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import pmu_link_pkg::*;
	localparam int SS = 60;
	localparam int Q = I2C_QUARTER_CYCLES;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic below, recov, warn, over, cool, vsel, mon_on, irq_oe, ack;
	logic [3:0] awaddr, araddr, wstrb, fault, bat_code, reg_on, ss;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] q;
	logic [NUM_SEL-1:0][VSET_W-1:0] vset;
	int miscompares, check_count;
	pmu_i2c_link_if link();
	pmu_i2c_link_if link2();
	pmu_i2c_host_ctrl i_pmu_i2c_host_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
	pmu_i2c_housekeeping_ctrl #(.SOFT_START_CYCLES_P(SS)) i_pmu_i2c_housekeeping_ctrl (.aclk(aclk),
		.aresetn(aresetn), .link(link), .battery_below_raw(below), .battery_recovered_raw(recov),
		.temp_warn_raw(warn), .temp_over_raw(over), .temp_cooled_raw(cool), .voltage_select_pin(vsel),
		.reg_fault_raw(fault), .battery_threshold_code(bat_code), .battery_monitor_on(mon_on),
		.reg_on(reg_on), .soft_start(ss), .vset_target(vset), .interrupt_out_n_o(), .interrupt_out_n_oe(irq_oe));
	// Second device faces a hand-driven master with a wrong address, then with its own address
	pmu_i2c_housekeeping_ctrl #(.SOFT_START_CYCLES_P(SS)) i_pmu_i2c_housekeeping_ctrl_2 (.aclk(aclk),
		.aresetn(aresetn), .link(link2), .battery_below_raw(below), .battery_recovered_raw(recov),
		.temp_warn_raw(warn), .temp_over_raw(over), .temp_cooled_raw(cool), .voltage_select_pin(vsel),
		.reg_fault_raw(fault), .battery_threshold_code(), .battery_monitor_on(), .reg_on(), .soft_start(),
		.vset_target(), .interrupt_out_n_o(), .interrupt_out_n_oe());
	pmu_i2c_link_props i_pmu_i2c_link_props (.aclk(aclk), .aresetn(aresetn), .host_scl_o(link.host_scl_o),
		.host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
	always #5 aclk = ~aclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic settle;
		repeat (8) @(posedge aclk);
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic dev_op(input logic rd, input logic [7:0] r, input logic [7:0] d);
		axi_wr(HOST_CMD, {15'h0000, rd, d, r}, resp);
		check(32'(resp), 32'(AXI_OKAY));
		v = 32'h0000_0001;
		while (v[ST_BUSY_BIT] === 1'b1) axi_rd(HOST_STATUS, v, resp);
		check(32'(v[2:0]), 32'h0000_0004);
		axi_rd(HOST_RDATA, v, resp);
		q = v[7:0];
	endtask
	task automatic ss_window(input logic [3:0] m);
		int n;
		n = 0;
		while ((ss & m) !== m && n < 20) begin
			@(posedge aclk);
			n++;
		end
		repeat (SS - 4) @(posedge aclk);
		check(32'(ss & m), 32'(m));
		repeat (8) @(posedge aclk);
		check(32'(ss & m), 32'h0000_0000);
	endtask
	task automatic bb_bit(input logic b);
		link2.host_sda_oe <= !b;
		repeat (Q) @(posedge aclk);
		link2.host_scl_oe <= 1'b0;
		repeat (Q) @(posedge aclk);
		ack = link2.sda;
		repeat (Q) @(posedge aclk);
		link2.host_scl_oe <= 1'b1;
		repeat (Q) @(posedge aclk);
	endtask
	task automatic bb_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) bb_bit(b[i]);
		bb_bit(1'b1);
	endtask
	task automatic bb_start;
		link2.host_sda_oe <= 1'b1;
		repeat (2 * Q) @(posedge aclk);
		link2.host_scl_oe <= 1'b1;
		repeat (2 * Q) @(posedge aclk);
	endtask
	task automatic bb_stop;
		link2.host_sda_oe <= 1'b1;
		repeat (Q) @(posedge aclk);
		link2.host_scl_oe <= 1'b0;
		repeat (Q) @(posedge aclk);
		link2.host_sda_oe <= 1'b0;
		repeat (2 * Q) @(posedge aclk);
	endtask
	initial begin
		repeat (100000) @(posedge aclk);
		miscompares++;
		end_of_test;
	end
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{below, recov, warn, over, cool, vsel, fault} = '0;
		wstrb = 4'hf;
		{link2.host_scl_o, link2.host_scl_oe, link2.host_sda_o, link2.host_sda_oe} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		settle;
		check({mon_on, bat_code, reg_on, vset, irq_oe, ss}, 32'h0000_0000);
		axi_rd(4'hc, v, resp);
		check({v[29:0], resp}, 32'(AXI_SLVERR));
		axi_wr(HOST_STATUS, 32'h0000_0000, resp);
		check(32'(resp), 32'(AXI_SLVERR));
		dev_op(1'b1, REG_BATTERY, 8'h00);
		check(32'(q), 32'h0000_0000);
		axi_rd(HOST_CMD, v, resp);
		check(v, 32'h0001_0000);
		below <= 1'b1;
		dev_op(1'b0, REG_BATTERY, 8'h0f);
		check({mon_on, bat_code, irq_oe}, 32'h0000_003e);
		dev_op(1'b1, REG_STATUS, 8'h00);
		check(32'(q), 32'h0000_0001);
		dev_op(1'b0, REG_BATTERY, 8'h2f);
		check(32'(irq_oe), 32'h0000_0001);
		below <= 1'b0;
		settle;
		check(32'(irq_oe), 32'h0000_0001);
		recov <= 1'b1;
		settle;
		check(32'(irq_oe), 32'h0000_0000);
		recov <= 1'b0;
		warn <= 1'b1;
		settle;
		check(32'(irq_oe), 32'h0000_0000);
		dev_op(1'b0, REG_THERMAL, 8'h01);
		check(32'(irq_oe), 32'h0000_0001);
		warn <= 1'b0;
		settle;
		check(32'(irq_oe), 32'h0000_0000);
		dev_op(1'b0, REG_ENABLE, 8'h0f);
		check(32'(reg_on), 32'h0000_000f);
		fault[0] <= 1'b1;
		settle;
		fault[0] <= 1'b0;
		ss_window(4'h1);
		over <= 1'b1;
		settle;
		check(32'(reg_on), 32'h0000_0000);
		over <= 1'b0;
		settle;
		check(32'(reg_on), 32'h0000_0000);
		cool <= 1'b1;
		ss_window(4'hf);
		check(32'(reg_on), 32'h0000_000f);
		cool <= 1'b0;
		dev_op(1'b0, REG_VSET_A_BASE + 8'h01, 8'h15);
		check(32'(vset), 32'h0000_0540);
		vsel <= 1'b1;
		settle;
		check(32'(vset), 32'h0000_0000);
		bb_start;
		bb_byte(8'ha4);
		check(32'(ack), 32'h0000_0001);
		bb_byte(8'hb4);
		check(32'(ack), 32'h0000_0001);
		bb_stop;
		bb_start;
		bb_byte(8'hb4);
		check(32'(ack), 32'h0000_0000);
		bb_stop;
		end_of_test;
	end
endmodule // tb_pmu_i2c_housekeeping_ctrl
